// ===== logic/lieb_event_bank.sv
/*
  Interrupt event register bank of a serial bus link controller: sticky
  event bits 29 and 27..23 with set, clear, mask and one interrupt output.
  Assumes a register master on mclk_i with one-cycle strobes, and event
  sources produced by link logic on the same clock.
*/
// Behaviour
// (RL1) Event bit sets on rising edge of its source or a set-address one.
// (RL2) Event bit clears only by writing one at the clear address.
// (RL3) Reading set or clear address returns events ANDed with mask.
// (RL4) Bits 31 and 30 read zero; writes change nothing.
// (RL5) Bit 28 is reserved: reads zero, ignores writes.
// (RL6) Bit 29 is software-only, changed through set and clear writes.
// (RL7) Bit 27 sets only with late-ack enable, on fifo, busy or tardy.
// (RL8) Bit 26 sets on PHY byte arrival; byte readable in bits 23..16.
// (RL9) With cycle-origin role, bit 25 sets when a cycle exceeds 125 us.
// (RL10) Overlong cycle event clears the cycle-origin role bit.
// (RL11) Bit 24 sets when an error halts any subunit.
// (RL12) While bit 24 is set, halted contexts' normal interrupts are blocked.
// (RL13) Bit 23 sets when received cycle start disagrees with cycle timer.
// (RL14) Interrupt output is high while masked events are nonzero.
`timescale 1ns/1ps
`include "lieb_map.svh"

module lieb_event_bank #(
  parameter int N_CTX = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire lieb_pkg::lieb_addr_t reg_addr_i,
  input wire lieb_pkg::lieb_word_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output lieb_pkg::lieb_word_t reg_rdata_o,
  // Late acknowledge sources
  input wire logic rx_fifo_pending_i,
  input wire logic phys_resp_busy_i,
  input wire logic late_ack_sent_i,
  // PHY register byte
  input wire logic phy_reg_byte_arrived_i,
  input wire logic [7:0] phy_reg_byte_i,
  // Cycle timing
  input wire logic cs_tx_start_i,
  input wire logic subaction_gap_end_i,
  input wire logic cs_rx_valid_i,
  input wire lieb_pkg::lieb_word_t cs_rx_stamp_i,
  input wire lieb_pkg::lieb_word_t cycle_timer_i,
  // Subunit halts
  input wire logic [N_CTX-1:0] subunit_halt_i,
  // Outputs
  output logic [N_CTX-1:0] ctx_irq_block_o,
  output logic cycle_origin_role_o,
  output logic irq_o
);
  import lieb_pkg::*;

  localparam int SRC_W = 4;
  localparam int SRC_LATE = 0;
  localparam int SRC_PHY = 1;
  localparam int SRC_FATAL = 2;
  localparam int SRC_MISMATCH = 3;
  localparam lieb_word_t IMPL = `LIEB_EV_IMPL;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic lieb_sel_t decode(input lieb_addr_t addr);
    lieb_sel_t sel;
    sel = SEL_NONE;
    if (addr == `LIEB_OFF_EV_SET) begin
      sel = SEL_SET;
    end else if (addr == `LIEB_OFF_EV_CLR) begin
      sel = SEL_CLR;
    end else if (addr == `LIEB_OFF_MASK) begin
      sel = SEL_MASK;
    end else if (addr == `LIEB_OFF_CTRL) begin
      sel = SEL_CTRL;
    end else if (addr == `LIEB_OFF_PHY) begin
      sel = SEL_PHY;
    end
    return sel;
  endfunction

  lieb_sel_t sel;
  logic wr_set, wr_clr, wr_mask, wr_ctrl;

  assign sel = decode(reg_addr_i);
  assign wr_set = reg_wr_i && (sel == SEL_SET);
  assign wr_clr = reg_wr_i && (sel == SEL_CLR);
  assign wr_mask = reg_wr_i && (sel == SEL_MASK);
  assign wr_ctrl = reg_wr_i && (sel == SEL_CTRL);

  // ****************************************************************
  // State
  // ****************************************************************
  lieb_word_t ev_reg, ev_next;
  lieb_word_t mask_reg;
  lieb_word_t mask_next;
  lieb_word_t ev_masked;
  lieb_word_t sw_set, sw_clr, hw_set;
  logic late_en_reg;
  logic role_reg;
  logic [7:0] phy_byte_reg;
  logic [N_CTX-1:0] block_next;
  logic late_cond, stamp_differs;

  lieb_src_if #(.W(SRC_W)) sif ();

  // ****************************************************************
  // Event sources
  // ****************************************************************
  assign late_cond = rx_fifo_pending_i || phys_resp_busy_i || late_ack_sent_i;
  assign stamp_differs =
    (cs_rx_stamp_i[`LIEB_SEC_MSB:`LIEB_SEC_LSB] !=
     cycle_timer_i[`LIEB_SEC_MSB:`LIEB_SEC_LSB]) ||
    (cs_rx_stamp_i[`LIEB_TICK_MSB:`LIEB_TICK_LSB] !=
     cycle_timer_i[`LIEB_TICK_MSB:`LIEB_TICK_LSB]);

  assign sif.lvl[SRC_LATE] = late_en_reg && late_cond; // RL7
  assign sif.lvl[SRC_PHY] = phy_reg_byte_arrived_i; // RL8
  assign sif.lvl[SRC_FATAL] = |subunit_halt_i; // RL11
  assign sif.lvl[SRC_MISMATCH] = cs_rx_valid_i && stamp_differs; // RL13
  assign sif.cs_start = cs_tx_start_i;
  assign sif.gap_end = subaction_gap_end_i;
  assign sif.role = role_reg; // RL9

  lieb_edge_detect #(.W(SRC_W)) u_edge (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .sif(sif.det)
  );

  lieb_overlong_timer #(.CNT_W(12)) u_timer (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .sif(sif.tmr)
  );

  // ****************************************************************
  // Event bits
  // ****************************************************************
  always_comb begin
    hw_set = '0;
    hw_set[`LIEB_BIT_LATE_ACK] = sif.rise[SRC_LATE]; // RL7
    hw_set[`LIEB_BIT_PHY_BYTE] = sif.rise[SRC_PHY]; // RL8
    hw_set[`LIEB_BIT_OVERLONG] = sif.overlong; // RL9
    hw_set[`LIEB_BIT_FATAL] = sif.rise[SRC_FATAL]; // RL11
    hw_set[`LIEB_BIT_MISMATCH] = sif.rise[SRC_MISMATCH]; // RL13
  end

  // Reserved positions are masked off, so writes there change nothing
  assign sw_set = wr_set ? (reg_wdata_i & IMPL) : '0; // RL1 RL4 RL5 RL6
  assign sw_clr = wr_clr ? (reg_wdata_i & IMPL) : '0; // RL2 RL6

  // A set in the same cycle as a clear wins
  assign ev_next = ((ev_reg & ~sw_clr) | sw_set | hw_set) & IMPL; // RL1 RL2

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ev_reg <= `LIEB_EV_RESET;
    end else begin
      ev_reg <= ev_next;
    end
  end

  // Reserved positions of the mask cannot be written either
  assign mask_next = wr_mask ? (reg_wdata_i & IMPL) : mask_reg;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mask_reg <= `LIEB_MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  assign ev_masked = ev_reg & mask_reg;

  // ****************************************************************
  // Control bits
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      late_en_reg <= 1'(`LIEB_CTRL_RESET >> `LIEB_CTRL_LATE_EN);
    end else if (wr_ctrl) begin
      late_en_reg <= reg_wdata_i[`LIEB_CTRL_LATE_EN];
    end
  end

  // The overlong event takes priority over a software write of the role
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      role_reg <= 1'b0;
    end else if (sif.overlong) begin
      role_reg <= 1'b0; // RL10
    end else if (wr_ctrl) begin
      role_reg <= reg_wdata_i[`LIEB_CTRL_ROLE];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cycle_origin_role_o <= 1'b0;
    end else if (sif.overlong) begin
      cycle_origin_role_o <= 1'b0; // RL10
    end else if (wr_ctrl) begin
      cycle_origin_role_o <= reg_wdata_i[`LIEB_CTRL_ROLE];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      phy_byte_reg <= 8'h00;
    end else if (phy_reg_byte_arrived_i) begin
      phy_byte_reg <= phy_reg_byte_i; // RL8
    end
  end

  // ****************************************************************
  // Halted context blocking
  // ****************************************************************
  assign block_next = ev_next[`LIEB_BIT_FATAL] ?
    (ctx_irq_block_o | subunit_halt_i) : '0;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctx_irq_block_o <= '0;
    end else begin
      ctx_irq_block_o <= block_next; // RL12
    end
  end

  // ****************************************************************
  // Read port and interrupt
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= '0;
    end else if (sel == SEL_SET || sel == SEL_CLR) begin
      reg_rdata_o <= ev_masked; // RL3 RL4 RL5
    end else if (sel == SEL_MASK) begin
      reg_rdata_o <= mask_reg;
    end else if (sel == SEL_CTRL) begin
      reg_rdata_o <= {30'h0000_0000, role_reg, late_en_reg};
    end else if (sel == SEL_PHY) begin
      reg_rdata_o <= {8'h00, phy_byte_reg, 16'h0000}; // RL8
    end else begin
      reg_rdata_o <= '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      // The next mask keeps irq_o in step with the masked read after a mask write
      irq_o <= |(ev_next & mask_next); // RL14
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_clear_write(int b);
    wr_clr && reg_wdata_i[b];
  endsequence

  sequence s_bit_low(int b);
    ##1 !ev_reg[b];
  endsequence

  a_soft_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL2
    s_clear_write(`LIEB_BIT_SOFT) |-> s_bit_low(`LIEB_BIT_SOFT))
    else $error("Software event bit not cleared by clear write");

  a_no_stray_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL2
    1'b1 |=> (($past(ev_reg) & ~$past(sw_clr) & ~ev_reg) == '0))
    else $error("Event bit dropped without a clear write");

  a_soft_set: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL6
    wr_set && reg_wdata_i[`LIEB_BIT_SOFT] |=> ev_reg[`LIEB_BIT_SOFT] ##1
    ev_reg[`LIEB_BIT_SOFT] || $past(wr_clr))
    else $error("Software event bit not set by set write");

  a_soft_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL6
    !wr_set && !wr_clr |=> $stable(ev_reg[`LIEB_BIT_SOFT]))
    else $error("Software event bit moved without a write");

  a_read_masked: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL3
    reg_rd_i && (sel == SEL_SET || sel == SEL_CLR) |=> reg_rdata_o == $past(ev_masked))
    else $error("Event read is not events ANDed with mask");

  a_rsvd_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL4
    $past(reg_rd_i) |-> reg_rdata_o[31:30] == 2'b00 || $past(sel) == SEL_MASK)
    else $error("Reserved bits 31 and 30 read nonzero");

  a_bit28_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL5
    ev_reg[28] == 1'b0 && mask_reg[28] == 1'b0 && ev_reg[31:30] == 2'b00)
    else $error("Reserved event state became nonzero");

  a_late_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL7
    !late_en_reg && !ev_reg[`LIEB_BIT_LATE_ACK] && !sw_set[`LIEB_BIT_LATE_ACK]
    |=> !ev_reg[`LIEB_BIT_LATE_ACK])
    else $error("Late ack event set while disabled");

  a_phy_byte: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL8
    $rose(phy_reg_byte_arrived_i) |=> ev_reg[`LIEB_BIT_PHY_BYTE] &&
    phy_byte_reg == $past(phy_reg_byte_i))
    else $error("PHY byte arrival not recorded");

  a_role_drop: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL10
    sif.overlong |=> !role_reg && !cycle_origin_role_o && ev_reg[`LIEB_BIT_OVERLONG])
    else $error("Overlong cycle did not drop the role bit");

  a_fatal_set: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL11
    $rose(|subunit_halt_i) |=> ev_reg[`LIEB_BIT_FATAL])
    else $error("Subunit halt did not raise fatal event");

  a_block_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL12
    (ctx_irq_block_o != '0) == ev_reg[`LIEB_BIT_FATAL] ||
    (ev_reg[`LIEB_BIT_FATAL] && ctx_irq_block_o == '0 && subunit_halt_i == '0 &&
     $past(subunit_halt_i) == '0))
    else $error("Context block disagrees with fatal event");

  a_mismatch: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL13
    cs_rx_valid_i && stamp_differs && !$past(sif.lvl[SRC_MISMATCH])
    |=> ev_reg[`LIEB_BIT_MISMATCH])
    else $error("Cycle stamp mismatch not recorded");

  a_irq_level: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL14
    irq_o == (ev_masked != '0))
    else $error("Interrupt output disagrees with masked events");

  a_set_wins: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL1
    (hw_set != '0) |=> ((ev_reg & $past(hw_set)) == $past(hw_set)))
    else $error("Hardware event lost to a simultaneous clear");

  a_role_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL10
    wr_ctrl && !sif.overlong |=> role_reg == $past(reg_wdata_i[`LIEB_CTRL_ROLE]) &&
    cycle_origin_role_o == role_reg)
    else $error("Role bit did not follow a control write");

endmodule

// ===== logic/lieb_map.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  link interrupt event bank. Assumes inclusion by bare name from logic/.
*/
`ifndef LIEB_MAP_SVH
`define LIEB_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LIEB_OFF_EV_SET 8'h80
`define LIEB_OFF_EV_CLR 8'h84
`define LIEB_OFF_MASK 8'h88
`define LIEB_OFF_CTRL 8'h8c
`define LIEB_OFF_PHY 8'h90

// ****************************************************************
// Event bit positions
// ****************************************************************
`define LIEB_BIT_SOFT 29
`define LIEB_BIT_LATE_ACK 27
`define LIEB_BIT_PHY_BYTE 26
`define LIEB_BIT_OVERLONG 25
`define LIEB_BIT_FATAL 24
`define LIEB_BIT_MISMATCH 23
`define LIEB_EV_IMPL 32'h2f80_0000
`define LIEB_EV_RESET 32'h0000_0000
`define LIEB_MASK_RESET 32'h0000_0000

// ****************************************************************
// Control and data fields
// ****************************************************************
`define LIEB_CTRL_LATE_EN 0
`define LIEB_CTRL_ROLE 1
`define LIEB_CTRL_RESET 2'h0
`define LIEB_PHY_MSB 23
`define LIEB_PHY_LSB 16
`define LIEB_SEC_MSB 31
`define LIEB_SEC_LSB 25
`define LIEB_TICK_MSB 24
`define LIEB_TICK_LSB 12

// ****************************************************************
// Timing
// ****************************************************************
`define LIEB_CLK_PERIOD_NS 100
`define LIEB_OVERLONG_NS 125000

`endif

// ===== logic/lieb_pkg.sv
/*
  Types shared by the link interrupt event bank modules.
  Assumes nothing of its surroundings.
*/
package lieb_pkg;

  typedef logic [31:0] lieb_word_t;
  typedef logic [7:0] lieb_addr_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_SET,
    SEL_CLR,
    SEL_MASK,
    SEL_CTRL,
    SEL_PHY
  } lieb_sel_t;

  typedef enum logic {
    TMR_IDLE,
    TMR_RUN
  } lieb_tmr_state_t;

endpackage

// ===== logic/lieb_src_if.sv
/*
  Event source carrier between the bank and its edge detector and
  overlong-cycle timer. Assumes all ends run on mclk_i.
*/
`timescale 1ns/1ps

interface lieb_src_if #(parameter int W = 4);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic cs_start;
  logic gap_end;
  logic role;
  logic overlong;

  modport det (input lvl, output rise);
  modport tmr (input cs_start, input gap_end, input role, output overlong);
  modport bank (output lvl, output cs_start, output gap_end, output role,
    input rise, input overlong);
endinterface

// ===== logic/lieb_edge_detect.sv
/*
  Rising edge detector for a vector of event sources.
  Assumes sources come from logic on mclk_i.
*/
`timescale 1ns/1ps

module lieb_edge_detect #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Sources and edges
  lieb_src_if.det sif
);
  import lieb_pkg::*;

  logic [W-1:0] prev_reg;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= sif.lvl;
    end
  end

  assign sif.rise = sif.lvl & ~prev_reg;

  a_edge_single: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    sif.rise != '0 |=> (sif.rise & $past(sif.rise)) == '0) // RL1
    else $error("Edge reported on two consecutive cycles");

endmodule

// ===== logic/lieb_overlong_timer.sv
/*
  Overlong cycle timer: flags a cycle whose start packet and following
  subaction gap span more than the cycle limit. Assumes one-cycle start
  and gap-end pulses on mclk_i.
*/
`timescale 1ns/1ps
`include "lieb_map.svh"

module lieb_overlong_timer #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Timer signals
  lieb_src_if.tmr sif
);
  import lieb_pkg::*;

  localparam int LIMIT_CYC = `LIEB_OVERLONG_NS / `LIEB_CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(LIMIT_CYC);

  lieb_tmr_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic overlong_reg;
  logic [CNT_W:0] since_start;

  // Cycle start to gap end measurement
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg <= TMR_IDLE;
      cnt_reg <= '0;
      overlong_reg <= 1'b0;
    end else begin
      overlong_reg <= 1'b0;
      case (state_reg)
        TMR_IDLE: begin
          if (sif.cs_start && sif.role) begin
            state_reg <= TMR_RUN;
            cnt_reg <= '0;
          end
        end
        TMR_RUN: begin
          if (!sif.role || sif.gap_end) begin
            state_reg <= TMR_IDLE;
          end else if (cnt_reg == LIMIT) begin
            overlong_reg <= 1'b1; // RL9
            state_reg <= TMR_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: state_reg <= TMR_IDLE;
      endcase
    end
  end

  assign sif.overlong = overlong_reg;

  // Cycles since the last accepted start, for checking only
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      since_start <= '0;
    end else if (state_reg == TMR_IDLE && sif.cs_start && sif.role) begin
      since_start <= '0;
    end else if (since_start != '1) begin
      since_start <= since_start + 1'b1;
    end
  end

  a_overlong_late: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(overlong_reg) |-> since_start == (CNT_W+1)'(LIMIT_CYC + 1)) // RL9
    else $error("Overlong flagged at the wrong time");

endmodule

// ===== verif/testbench.sv
/*
  Self-checking bench of the link interrupt event bank: register rows, then
  late-ack, PHY byte, mismatch, halt, overlong and reset cases.
  Assumes the logic/ files are compiled first and lieb_map.svh is on the include path.
*/
`timescale 1ns/1ps
`include "lieb_map.svh"

module testbench;
  import lieb_pkg::*;

  typedef struct {
    lieb_addr_t wa;
    lieb_word_t wd;
    lieb_addr_t ra;
    lieb_word_t exp;
    logic irq;
  } lieb_tb_row_t;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  lieb_addr_t reg_addr_i = 8'h00;
  lieb_word_t reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  lieb_word_t reg_rdata_o;
  logic [2:0] late_src = 3'h0;
  logic phy_arr = 1'b0;
  logic [7:0] phy_byte = 8'h00;
  logic cs_start = 1'b0;
  logic gap_end = 1'b0;
  logic cs_valid = 1'b0;
  lieb_word_t cs_stamp = 32'h0;
  lieb_word_t cyc_timer = 32'h4a6c_3123;
  logic [3:0] halt = 4'h0;
  logic [3:0] irq_block;
  logic role;
  logic irq_o;
  lieb_word_t rd_val;
  lieb_tb_row_t rows [13];
  lieb_word_t stamps [4];
  int fails = 0;
  int compares = 0;

  always #50 mclk_i = ~mclk_i;

  lieb_event_bank #(.N_CTX(4)) dut (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .rx_fifo_pending_i(late_src[0]),
    .phys_resp_busy_i(late_src[1]),
    .late_ack_sent_i(late_src[2]),
    .phy_reg_byte_arrived_i(phy_arr),
    .phy_reg_byte_i(phy_byte),
    .cs_tx_start_i(cs_start),
    .subaction_gap_end_i(gap_end),
    .cs_rx_valid_i(cs_valid),
    .cs_rx_stamp_i(cs_stamp),
    .cycle_timer_i(cyc_timer),
    .subunit_halt_i(halt),
    .ctx_irq_block_o(irq_block),
    .cycle_origin_role_o(role),
    .irq_o(irq_o)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk_word(input lieb_word_t got, input lieb_word_t exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: flags %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic reg_wr(input lieb_addr_t a, input lieb_word_t d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input lieb_addr_t a, input lieb_word_t exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    rd_val = reg_rdata_o;
    chk_word(rd_val, exp);
    tick(1);
    chk_word(reg_rdata_o, 32'h0);
  endtask

  task automatic pulse_start();
    @(posedge mclk_i);
    cs_start <= 1'b1;
    @(posedge mclk_i);
    cs_start <= 1'b0;
  endtask

  task automatic wrap_up();
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    #(20000 * 100);
    fails++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rows = '{
      '{`LIEB_OFF_EV_SET, 32'h2000_0000, `LIEB_OFF_EV_SET, 32'h2000_0000, 1'b1},
      '{`LIEB_OFF_EV_CLR, 32'h0000_0000, `LIEB_OFF_EV_CLR, 32'h2000_0000, 1'b1},
      '{`LIEB_OFF_EV_SET, 32'h0000_0000, `LIEB_OFF_EV_SET, 32'h2000_0000, 1'b1},
      '{`LIEB_OFF_EV_CLR, 32'h2000_0000, `LIEB_OFF_EV_SET, 32'h0000_0000, 1'b0},
      '{`LIEB_OFF_EV_SET, 32'hd000_0000, `LIEB_OFF_EV_CLR, 32'h0000_0000, 1'b0},
      '{`LIEB_OFF_EV_SET, 32'hffff_ffff, `LIEB_OFF_EV_SET, 32'h2f80_0000, 1'b1},
      '{`LIEB_OFF_EV_CLR, 32'h0f80_0000, `LIEB_OFF_EV_CLR, 32'h2000_0000, 1'b1},
      '{`LIEB_OFF_MASK, 32'h2000_0000, `LIEB_OFF_EV_SET, 32'h2000_0000, 1'b1},
      '{`LIEB_OFF_EV_CLR, 32'h2000_0000, `LIEB_OFF_EV_SET, 32'h0000_0000, 1'b0},
      '{`LIEB_OFF_EV_SET, 32'h0f80_0000, `LIEB_OFF_EV_SET, 32'h0000_0000, 1'b0},
      '{`LIEB_OFF_MASK, 32'hffff_ffff, `LIEB_OFF_MASK, 32'h2f80_0000, 1'b1},
      '{`LIEB_OFF_EV_CLR, 32'hffff_ffff, `LIEB_OFF_EV_CLR, 32'h0000_0000, 1'b0},
      '{8'h40, 32'hffff_ffff, 8'h40, 32'h0000_0000, 1'b0}
    };
    stamps = '{32'h4a6c_3123, 32'h4a6c_3fff, 32'hca6c_3123, 32'h4a6c_2123};
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    tick(1);
    chk_bits({irq_o, role, 2'b00}, 4'h0);
    chk_bits(irq_block, 4'h0);
    rd_chk(`LIEB_OFF_MASK, 32'h0);
    rd_chk(`LIEB_OFF_CTRL, 32'h0);
    reg_wr(`LIEB_OFF_MASK, 32'hffff_ffff);
    rd_chk(`LIEB_OFF_EV_SET, 32'h0);
    for (int i = 0; i < 13; i++) begin
      reg_wr(rows[i].wa, rows[i].wd);
      chk_bits({3'h0, irq_o}, {3'h0, rows[i].irq});
      rd_chk(rows[i].ra, rows[i].exp);
    end

    // Late ack: all sources with enable off, then each source alone
    for (int k = 0; k < 4; k++) begin
      reg_wr(`LIEB_OFF_CTRL, (k == 0) ? 32'h0 : 32'h1);
      @(posedge mclk_i);
      late_src <= (k == 0) ? 3'h7 : 3'h1 << (k - 1);
      @(posedge mclk_i);
      late_src <= 3'h0;
      tick(1);
      rd_chk(`LIEB_OFF_EV_SET, (k == 0) ? 32'h0 : 32'h0800_0000);
      reg_wr(`LIEB_OFF_EV_CLR, 32'h0800_0000);
    end

    @(posedge mclk_i);
    phy_arr <= 1'b1;
    phy_byte <= 8'h5a;
    @(posedge mclk_i);
    phy_arr <= 1'b0;
    phy_byte <= 8'h00;
    tick(1);
    rd_chk(`LIEB_OFF_EV_SET, 32'h0400_0000);
    rd_chk(`LIEB_OFF_PHY, 32'h005a_0000);
    chk_bits({3'h0, irq_o}, 4'h1);
    reg_wr(`LIEB_OFF_EV_CLR, 32'h0400_0000);

    // Stamps: equal, offset only, seconds differ, count differs
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_i);
      cs_stamp <= stamps[k];
      cs_valid <= 1'b1;
      @(posedge mclk_i);
      cs_valid <= 1'b0;
      tick(1);
      rd_chk(`LIEB_OFF_EV_SET, (k < 2) ? 32'h0 : 32'h0080_0000);
      reg_wr(`LIEB_OFF_EV_CLR, 32'h0080_0000);
    end

    @(posedge mclk_i);
    halt <= 4'h2;
    tick(2);
    rd_chk(`LIEB_OFF_EV_SET, 32'h0100_0000);
    chk_bits(irq_block, 4'h2);
    @(posedge mclk_i);
    halt <= 4'h6;
    tick(2);
    chk_bits(irq_block, 4'h6);
    reg_wr(`LIEB_OFF_EV_CLR, 32'h0100_0000);
    chk_bits(irq_block, 4'h0);
    rd_chk(`LIEB_OFF_EV_SET, 32'h0);
    @(posedge mclk_i);
    halt <= 4'h0;

    // Overlong: gap in time, then no gap, then no role
    reg_wr(`LIEB_OFF_CTRL, 32'h2);
    chk_bits({3'h0, role}, 4'h1);
    pulse_start();
    tick(998);
    @(posedge mclk_i);
    gap_end <= 1'b1;
    @(posedge mclk_i);
    gap_end <= 1'b0;
    tick(400);
    rd_chk(`LIEB_OFF_EV_SET, 32'h0);
    chk_bits({3'h0, role}, 4'h1);
    pulse_start();
    tick(1240);
    rd_chk(`LIEB_OFF_EV_SET, 32'h0);
    tick(15);
    rd_chk(`LIEB_OFF_EV_SET, 32'h0200_0000);
    chk_bits({3'h0, role}, 4'h0);
    rd_chk(`LIEB_OFF_CTRL, 32'h0);
    reg_wr(`LIEB_OFF_EV_CLR, 32'h0200_0000);
    pulse_start();
    tick(1300);
    rd_chk(`LIEB_OFF_EV_SET, 32'h0);
    chk_bits({3'h0, irq_o}, 4'h0);

    // Reset in mid-run with events, mask, enable and role all set
    reg_wr(`LIEB_OFF_EV_SET, 32'h2f80_0000);
    reg_wr(`LIEB_OFF_CTRL, 32'h3);
    chk_bits({irq_o, role, 2'b00}, 4'hc);
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    tick(1);
    chk_bits({irq_o, role, 2'b00}, 4'h0);
    chk_bits(irq_block, 4'h0);
    rd_chk(`LIEB_OFF_MASK, 32'h0);
    rd_chk(`LIEB_OFF_CTRL, 32'h0);
    reg_wr(`LIEB_OFF_MASK, 32'hffff_ffff);
    rd_chk(`LIEB_OFF_EV_SET, 32'h0);
    wrap_up();
  end
endmodule
